// ### ext_ctrl_checker.sv
/* Port assertions for the extended device control register.
   Assumes default parameters: full pin set, PCI-X present, register at 12'h018. */
`timescale 1ns/100ps
module ext_ctrl_checker (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // EEPROM reload, pins, PHY and bus mastering
    input wire logic        eeprom_reload_pulse,
    input wire logic [1:0]  soft_defined_pin_in,
    input wire logic [1:0]  soft_defined_pin_out,
    input wire logic [1:0]  soft_defined_pin_oe_n,
    input wire logic [1:0]  input_pin_int_cause,
    input wire logic        phy_irq_value,
    input wire logic        pcix_mode,
    input wire logic        pcix_cmd_ro_enable,
    input wire logic        relaxed_order_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence rd_acc;
        psel && penable && !pwrite && paddr == 12'h018;
    endsequence
    sequence reload_req;
        psel && penable && pwrite && paddr == 12'h018 && pwdata[13];
    endsequence
    sequence pulse_once;
        eeprom_reload_pulse ##1 !eeprom_reload_pulse;
    endsequence
    rsvd_zero_a: assert property (
        rd_acc |-> !prdata[4] && !prdata[14] && !prdata[16] && prdata[20:18] == 3'h0
    ) else $error("reserved bit read nonzero");
    phy_live_a: assert property (rd_acc |-> prdata[5] == phy_irq_value)
        else $error("phy status not live");
    cause_gate_a: assert property (
        rd_acc |-> input_pin_int_cause == (prdata[3:2] & soft_defined_pin_oe_n & soft_defined_pin_in)
    ) else $error("pin cause not gated");
    pin_level_a: assert property (
        rd_acc |-> prdata[7:6] == ((~soft_defined_pin_oe_n & soft_defined_pin_out)
                                   | (soft_defined_pin_oe_n & soft_defined_pin_in))
    ) else $error("pin level mismatch");
    dir_map_a: assert property (rd_acc |-> soft_defined_pin_oe_n == ~prdata[11:10])
        else $error("direction not on enables");
    rsvd_fixed_a: assert property (rd_acc |-> prdata[9:8] == 2'b01)
        else $error("bits 9:8 not 01");
    reload_once_a: assert property (reload_req |=> pulse_once)
        else $error("reload pulse wrong");
    ro_req_a: assert property (
        rd_acc |-> relaxed_order_request == (pcix_mode && pcix_cmd_ro_enable && !prdata[17])
    ) else $error("relaxed order request wrong");
endmodule : ext_ctrl_checker

// ### ext_ctrl_defs.svh
/*
 Offsets, field positions, reset values and timing counts of the extended device control register.
 Assumes inclusion by bare name from the design files.
*/
`ifndef EXT_CTRL_DEFS_SVH
`define EXT_CTRL_DEFS_SVH
`define EXT_CTRL_OFFSET      12'h018
`define EXT_CTRL_OFFSET_W    12
`define POS_IRQ_EN_LO        0
`define POS_IRQ_EN_HI        3
`define POS_RSVD4            4
`define POS_PHY_IRQ          5
`define POS_PIN_A_LEVEL      6
`define POS_PIN_B_LEVEL      7
`define POS_RSVD98_LO        8
`define POS_RSVD98_HI        9
`define POS_PIN_A_DIR        10
`define POS_PIN_B_DIR        11
`define POS_SPEED_CHECK      12
`define POS_EEPROM_RELOAD    13
`define POS_SPEED_BYPASS     15
`define POS_RO_DISABLE       17
`define RSVD98_RESET         2'b01
`define PIN_DIR_RESET        2'b00
`define PIN_LEVEL_RESET      2'b00
`define SPEED_CHECK_NS       1000
`define CLK_PERIOD_NS        25
`define SPEED_CHECK_CYCLES   ((`SPEED_CHECK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### ext_ctrl_pkg.sv
/*
 Types shared by the extended device control register bank.
 Assumes the constants header is compiled alongside.
*/
package ext_ctrl_pkg;
    typedef enum logic [2:0] {
        SPD_IDLE    = 3'b001,
        SPD_MEASURE = 3'b010,
        SPD_REPORT  = 3'b100
    } speed_state_t;
endpackage : ext_ctrl_pkg

// ### extended_device_control_reg.sv
/*
 Extended device control register bank behind an APB slave, with two soft-defined pins.
 Assumes a power-on reset separate from system/software reset, and synchronous pin inputs.
*/
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`include "ext_ctrl_defs.svh"
module extended_device_control_reg #(
    parameter bit REDUCED_PIN   = 1'b0,
    parameter bit HAS_PCIX      = 1'b1,
    parameter int SPEED_WINDOW  = `SPEED_CHECK_CYCLES
) (
    // Clock and resets
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        por_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // EEPROM defaults and reload
    input  wire logic        eeprom_load,
    input  wire logic [1:0]  eeprom_pin_level,
    input  wire logic [1:0]  eeprom_pin_dir,
    output logic             eeprom_reload_pulse,
    // Soft-defined pins (index 0 is pin a, 1 is pin b)
    input  wire logic [1:0]  soft_defined_pin_in,
    output logic [1:0]       soft_defined_pin_out,
    output logic [1:0]       soft_defined_pin_oe_n,
    // Interrupt cause sources
    output logic [1:0]       input_pin_int_cause,
    // PHY and speed
    input  wire logic        phy_irq_value,
    input  wire logic        internal_phy_mode,
    input  wire logic        rx_clk_tick,
    input  wire logic [1:0]  ctrl_speed,
    input  wire logic [1:0]  switched_speed,
    output logic [1:0]       applied_speed,
    output logic [1:0]       detected_speed_value,
    output logic             speed_detect_busy,
    // Bus mastering
    input  wire logic        pcix_mode,
    input  wire logic        pcix_cmd_ro_enable,
    output logic             relaxed_order_request
);
    initial begin
        if (SPEED_WINDOW < 1)
            $error("extended_device_control_reg: SPEED_WINDOW must be positive");
    end

    typedef struct packed {
        logic [3:0] pin_interrupt_enables;
        logic [1:0] pin_level;
        logic [1:0] rsvd98;
        logic       speed_detect_check;
        logic       eeprom_reload;
        logic       speed_select_bypass;
        logic       relaxed_order_disable;
    } ctl_state_t;

    ctl_state_t cur_ff;
    ctl_state_t nxt_cur;
    logic [1:0] dir_ff;
    logic [1:0] nxt_dir;

    logic       wr_hit;
    logic       sel_reg;
    logic       sc_start;
    logic       sc_busy;
    logic [1:0] sc_code;
    logic [1:0] pin_level_rd;
    logic [1:0] en_eff;
    logic [31:0] rd_word;

    // Word index compare; byte lanes below bit 2 are ignored
    assign sel_reg = paddr[`EXT_CTRL_OFFSET_W-1:2] == (`EXT_CTRL_OFFSET_W-2)'(`EXT_CTRL_OFFSET >> 2);
    assign wr_hit  = psel && penable && pwrite && sel_reg;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !sel_reg;

    // Speed check only meaningful with internal PHY
    assign sc_start = cur_ff.speed_detect_check && internal_phy_mode;

    speed_check #(
        .WINDOW_CYCLES (SPEED_WINDOW),
        .CNT_W         (8)
    ) u_speed_check (
        .pclk        (pclk),
        .presetn     (presetn),
        .start       (sc_start),
        .rx_clk_tick (rx_clk_tick),
        .busy        (sc_busy),
        .done        (),
        .speed_code  (sc_code)
    );

    always_comb begin
        nxt_cur = cur_ff;
        nxt_dir = dir_ff;
        // Command bits are one-cycle launches
        nxt_cur.speed_detect_check = 1'b0;
        nxt_cur.eeprom_reload      = 1'b0;
        if (eeprom_load) begin
            nxt_cur.pin_level = eeprom_pin_level;
            nxt_dir           = eeprom_pin_dir;
        end
        if (wr_hit && pstrb[0]) begin
            nxt_cur.pin_interrupt_enables = REDUCED_PIN ? {pwdata[3:2], 2'b00} : pwdata[3:0];
            nxt_cur.pin_level = pwdata[`POS_PIN_B_LEVEL:`POS_PIN_A_LEVEL];
        end
        if (wr_hit && pstrb[1]) begin
            nxt_cur.rsvd98 = pwdata[`POS_RSVD98_HI:`POS_RSVD98_LO];
            nxt_dir        = pwdata[`POS_PIN_B_DIR:`POS_PIN_A_DIR];
            nxt_cur.speed_detect_check = pwdata[`POS_SPEED_CHECK] && !sc_busy;
            nxt_cur.eeprom_reload      = pwdata[`POS_EEPROM_RELOAD];
            nxt_cur.speed_select_bypass = pwdata[`POS_SPEED_BYPASS];
        end
        if (wr_hit && pstrb[2])
            nxt_cur.relaxed_order_disable = HAS_PCIX ? pwdata[`POS_RO_DISABLE] : 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cur_ff <= '{pin_interrupt_enables: 4'h0, pin_level: `PIN_LEVEL_RESET, rsvd98: `RSVD98_RESET,
                        speed_detect_check: 1'b0, eeprom_reload: 1'b0, speed_select_bypass: 1'b0,
                        relaxed_order_disable: 1'b0};
        else
            cur_ff <= nxt_cur;
    end

    // Direction held on power-on reset only, so system resets leave pin directions alone
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n)
            dir_ff <= `PIN_DIR_RESET;
        else
            dir_ff <= nxt_dir;
    end

    // Upper enable bits map onto the two pins in both variants
    assign en_eff = cur_ff.pin_interrupt_enables[3:2] & ~dir_ff;
    assign input_pin_int_cause = en_eff & soft_defined_pin_in;

    assign soft_defined_pin_out  = cur_ff.pin_level;
    assign soft_defined_pin_oe_n = ~dir_ff;
    assign pin_level_rd = (dir_ff & cur_ff.pin_level) | (~dir_ff & soft_defined_pin_in);

    assign eeprom_reload_pulse   = cur_ff.eeprom_reload;
    assign speed_detect_busy     = sc_busy;
    assign detected_speed_value  = sc_code;
    // Bypass forces the control field, skipping the clock-switching path
    assign applied_speed = cur_ff.speed_select_bypass ? ctrl_speed : switched_speed;
    assign relaxed_order_request = pcix_mode && pcix_cmd_ro_enable && !cur_ff.relaxed_order_disable;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_word[`POS_IRQ_EN_HI:`POS_IRQ_EN_LO] = cur_ff.pin_interrupt_enables;
        rd_word[`POS_RSVD4] = 1'b0;
        rd_word[`POS_PHY_IRQ] = REDUCED_PIN ? 1'b0 : phy_irq_value;
        rd_word[`POS_PIN_B_LEVEL:`POS_PIN_A_LEVEL] = pin_level_rd;
        rd_word[`POS_RSVD98_HI:`POS_RSVD98_LO] = cur_ff.rsvd98;
        rd_word[`POS_PIN_B_DIR:`POS_PIN_A_DIR] = dir_ff;
        rd_word[`POS_SPEED_CHECK] = cur_ff.speed_detect_check;
        rd_word[`POS_EEPROM_RELOAD] = cur_ff.eeprom_reload;
        rd_word[`POS_SPEED_BYPASS] = cur_ff.speed_select_bypass;
        rd_word[`POS_RO_DISABLE] = cur_ff.relaxed_order_disable;
    end

    assign prdata = (psel && !pwrite && sel_reg) ? rd_word : 32'h0000_0000;
endmodule : extended_device_control_reg

// ### speed_check.sv
/*
 Speed-detect diagnostic: counts receive clock ticks over a fixed window and reports a speed code.
 Assumes rx_clk_tick is a one-cycle pulse per PHY receive clock edge, synchronous to pclk.
*/
`timescale 1ns/100ps
`include "ext_ctrl_defs.svh"
module speed_check #(
    parameter int WINDOW_CYCLES = `SPEED_CHECK_CYCLES,
    parameter int CNT_W         = 8
) (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       start,
    input  wire logic       rx_clk_tick,
    // Result
    output logic            busy,
    output logic            done,
    output logic [1:0]      speed_code
);
    initial begin
        if (WINDOW_CYCLES < 1 || WINDOW_CYCLES >= (1 << 16) || CNT_W < 2)
            $error("speed_check: unsupported parameters");
    end

    typedef struct packed {
        ext_ctrl_pkg::speed_state_t st;
        logic [15:0]                win;
        logic [CNT_W-1:0]           ticks;
        logic [1:0]                 code;
    } sc_state_t;

    sc_state_t cur_ff;
    sc_state_t nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        unique case (cur_ff.st)
            ext_ctrl_pkg::SPD_IDLE: begin
                if (start) begin
                    nxt_cur.st    = ext_ctrl_pkg::SPD_MEASURE;
                    nxt_cur.win   = 16'(WINDOW_CYCLES);
                    nxt_cur.ticks = '0;
                end
            end
            ext_ctrl_pkg::SPD_MEASURE: begin
                // Saturate so a fast clock cannot wrap into a slow code
                if (rx_clk_tick && cur_ff.ticks != '1)
                    nxt_cur.ticks = cur_ff.ticks + 1'b1;
                nxt_cur.win = cur_ff.win - 16'h0001;
                if (cur_ff.win == 16'h0001)
                    nxt_cur.st = ext_ctrl_pkg::SPD_REPORT;
            end
            ext_ctrl_pkg::SPD_REPORT: begin
                if (cur_ff.ticks[CNT_W-1])
                    nxt_cur.code = 2'b10;
                else if (|cur_ff.ticks[CNT_W-2:CNT_W/2])
                    nxt_cur.code = 2'b01;
                else
                    nxt_cur.code = 2'b00;
                nxt_cur.st = ext_ctrl_pkg::SPD_IDLE;
            end
            default: nxt_cur.st = ext_ctrl_pkg::SPD_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cur_ff <= '{st: ext_ctrl_pkg::SPD_IDLE, win: 16'h0000, ticks: '0, code: 2'b00};
        else
            cur_ff <= nxt_cur;
    end

    assign busy       = cur_ff.st != ext_ctrl_pkg::SPD_IDLE;
    assign done       = cur_ff.st == ext_ctrl_pkg::SPD_REPORT;
    assign speed_code = cur_ff.code;
endmodule : speed_check

// ### tb_top.sv
/* Self-checking bench for the extended device control register.
   Assumes APB at 12'h018 and a 200-cycle speed window for the tests. */
`timescale 1ns/100ps
module tb_top;
    logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, eeprom_load, err;
    logic        eeprom_reload_pulse, phy_irq_value, internal_phy_mode, speed_detect_busy;
    logic        pcix_mode, pcix_cmd_ro_enable, relaxed_order_request;
    logic        rx_clk_tick = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic [3:0]  pstrb;
    logic [1:0]  eeprom_pin_level, eeprom_pin_dir, soft_defined_pin_in, soft_defined_pin_out;
    logic [1:0]  soft_defined_pin_oe_n, input_pin_int_cause, ctrl_speed, switched_speed;
    logic [1:0]  applied_speed, detected_speed_value;
    int          error_cnt, tests_run, div, cyc, i;

    extended_device_control_reg #(.SPEED_WINDOW(200)) dut (.*);

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Receive ticks every div cycles, none when div is zero
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        rx_clk_tick <= div != 0 && cyc % div == 0;
    end

    function automatic logic [31:0] exp_word(logic [31:0] s, logic [1:0] pin, logic phy);
        logic [1:0] lv;
        lv = (s[11:10] & s[7:6]) | (~s[11:10] & pin);
        return (s & 32'h0002_8F0F) | {24'h0, lv, phy, 5'h0};
    endfunction : exp_word

    task automatic close_out();
        if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Unbounded wait for pready; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [31:0] s);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, exp_word(s, soft_defined_pin_in, phy_irq_value));
    endtask : rd_chk

    // Bounded wait; a hang counts as a mismatch
    task automatic wait_busy(input logic v);
        int n;
        for (n = 0; n < 400 && speed_detect_busy !== v; n++) @(posedge pclk);
        chk({31'h0, speed_detect_busy}, {31'h0, v});
    endtask : wait_busy

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        close_out();
    end

    initial begin
        {presetn, por_n, psel, penable, pwrite, eeprom_load, phy_irq_value} = '0;
        {internal_phy_mode, pcix_mode, pcix_cmd_ro_enable} = '0;
        {paddr, pwdata, pstrb} = {12'h0, 32'h0, 4'hF};
        {eeprom_pin_level, eeprom_pin_dir, soft_defined_pin_in, ctrl_speed, switched_speed} = '0;
        i = $urandom(32'h51e4_34ec);
        repeat (8) @(posedge pclk);
        {presetn, por_n} <= 2'b11;
        rd_chk(32'h0000_0100);
        apb(1'b0, 12'h01c, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        for (i = 0; i < 40; i++) begin
            // Software side keeps 9:8 at 01 and other reserved bits zero
            w = ($urandom & 32'h0002_8CCF) | 32'h0000_0100;
            {pcix_mode, pcix_cmd_ro_enable, phy_irq_value} <= 3'($urandom);
            {soft_defined_pin_in, ctrl_speed, switched_speed} <= 6'($urandom);
            apb(1'b1, 12'h018, w);
            rd_chk(w);
            chk({30'h0, input_pin_int_cause}, {30'h0, w[3:2] & ~w[11:10] & soft_defined_pin_in});
            chk({30'h0, applied_speed}, {30'h0, w[15] ? ctrl_speed : switched_speed});
            chk({30'h0, soft_defined_pin_oe_n}, {30'h0, ~w[11:10]});
            chk({30'h0, soft_defined_pin_out & w[11:10]}, {30'h0, w[7:6] & w[11:10]});
            chk({31'h0, relaxed_order_request}, {31'h0, pcix_mode & pcix_cmd_ro_enable & ~w[17]});
        end
        // Direction survives system reset, not power-on
        apb(1'b1, 12'h018, 32'h0000_0D00);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(32'h0000_0D00);
        // EEPROM defaults land in level and direction
        {eeprom_pin_level, eeprom_pin_dir, eeprom_load} <= {2'b10, 2'b11, 1'b1};
        @(posedge pclk);
        eeprom_load <= 1'b0;
        rd_chk(32'h0000_0D80);
        chk({30'h0, soft_defined_pin_out}, {30'h0, 2'b10});
        {presetn, por_n} <= 2'b00;
        @(posedge pclk);
        {presetn, por_n} <= 2'b11;
        rd_chk(32'h0000_0100);
        // Everything else cleared before the reload request
        apb(1'b1, 12'h018, 32'h0000_2100);
        @(posedge pclk);
        chk({31'h0, eeprom_reload_pulse}, 32'h1);
        @(posedge pclk);
        chk({31'h0, eeprom_reload_pulse}, 32'h0);
        rd_chk(32'h0000_0100);
        apb(1'b1, 12'h018, 32'h0000_1100);
        repeat (3) @(posedge pclk);
        chk({31'h0, speed_detect_busy}, 32'h0);
        internal_phy_mode <= 1'b1;
        for (i = 0; i < 3; i++) begin
            div <= i == 0 ? 1 : i == 1 ? 4 : 0;
            apb(1'b1, 12'h018, 32'h0000_1100);
            wait_busy(1'b1);
            wait_busy(1'b0);
            @(posedge pclk);
            chk({30'h0, detected_speed_value}, {30'h0, i == 0 ? 2'b10 : i == 1 ? 2'b01 : 2'b00});
            rd_chk(32'h0000_0100);
        end
        close_out();
    end
endmodule : tb_top

bind extended_device_control_reg ext_ctrl_checker chk_i (.*);
